// *** hdl/flash_lock_device.sv ***
// Operation
// R1 - Key A5 then F1 enables flash change
// R2 - Relock after one write or erase
// R3 - Wrong key write locks until reset
// R4 - Write while locked locks until reset
// R5 - Software may force lock with non-A5
// R6 - Key read returns two-bit lock state
// R7 - Bypass zero: one-shot sets read time
// R8 - Bypass one: clock sets read time
// R9 - Reserved timing bits written as zero
// R10 - No filler needed after bypass clear
// R11 - Write enable: data write programs byte
// R12 - Erase plus write: erases addressed page
// R13 - One-shot pulses sense amps per access
// R14 - Perform only when unlocked and enabled
`timescale 1ns/10ps
module flash_lock_device (
  flash_lock_if.device             bus,
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                flash_access,
  output logic                     program_byte,
  output logic                     erase_page,
  output logic [7:0]               program_data,
  output logic                     sense_enable,
  output logic                     timing_bypass,
  output flash_lock_pkg::lock_state_e lock_state
);
  import flash_lock_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  lock_state_e lock_reg, lock_next;
  logic [7:0]  timing_reg, timing_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [3:0]  busy_reg, busy_next;
  logic        busy_flag_reg, busy_flag_next;
  logic        prog_reg, prog_next;
  logic        erase_reg, erase_next;
  logic [7:0]  pdata_reg, pdata_next;
  logic        sense_reg, sense_next;
  logic        key_wr;
  logic        tim_wr;
  logic        op_idle;
  logic        op_start;
  logic        op_refused;
  logic        op_done;

  // ************************************************************
  // Register port decode
  // ************************************************************
  // The key and timing registers share one address; a select picks the page.
  // Both strobes are single-cycle pulses from the host, so no edge detect is needed.
  assign key_wr = bus.sfr_wr && (bus.sfr_addr == key_lock_offset) && !bus.sfr_sel_timing;
  assign tim_wr = bus.sfr_wr && (bus.sfr_addr == read_timing_offset) && bus.sfr_sel_timing;

  // ************************************************************
  // Flash request decode
  // ************************************************************
  // A data write only counts as a flash request while program-store writes are enabled.
  // Requests that arrive while an operation runs are dropped, never queued.
  assign op_idle    = (busy_reg == 4'h0);
  assign op_start   = op_idle && bus.flash_wr && bus.program_store_write_enable
                      && (lock_reg == lock_unlocked); // R14
  assign op_refused = op_idle && bus.flash_wr && bus.program_store_write_enable
                      && (lock_reg != lock_unlocked); // R4
  assign op_done    = (busy_reg == 4'h1); // R2

  // ************************************************************
  // Lock sequencer
  // ************************************************************
  // Next lock state. A key violation on the edge that ends an operation must still win,
  // otherwise the automatic relock would quietly undo the permanent lock.
  always_comb begin
    lock_next = lock_reg;
    if (key_wr) begin
      case (lock_reg)
        lock_locked:   lock_next = (bus.sfr_wdata == key_first) ? lock_first : lock_disabled; // R1 R5 R3
        lock_first:    lock_next = (bus.sfr_wdata == key_second) ? lock_unlocked : lock_disabled; // R1 R3
        lock_unlocked: lock_next = lock_disabled; // R3
        lock_disabled: lock_next = lock_disabled;
        default:       lock_next = lock_disabled;
      endcase
    end
    if (op_refused) begin
      lock_next = lock_disabled; // R4
    end else if (op_done && (lock_next != lock_disabled)) begin
      lock_next = lock_locked; // R2
    end
  end

  // Lock state register; only a device reset leaves the disabled state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= lock_locked;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // ************************************************************
  // Read timing register
  // ************************************************************
  // Reserved bits are forced to zero so a careless write cannot leak into the read-back.
  always_comb begin
    timing_next = timing_reg;
    if (tim_wr) begin
      timing_next = bus.sfr_wdata & read_timing_mask; // R9
    end
  end

  // Timing register; the one-shot is in use after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_reg <= reg_reset_value;
    end else begin
      timing_reg <= timing_next;
    end
  end

  // ************************************************************
  // Register read-back
  // ************************************************************
  // Read data is captured on the read strobe and then held, so the host may take it
  // on any later cycle without racing a lock change.
  always_comb begin
    rdata_next = rdata_reg;
    if (bus.sfr_rd) begin
      if (bus.sfr_sel_timing) begin
        rdata_next = timing_reg;
      end else begin
        rdata_next = {6'h00, lock_reg}; // R6
      end
    end
  end

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= reg_reset_value;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Flash operation launch
  // ************************************************************
  // The macro is modelled as a fixed busy count. The busy flag is registered beside the
  // counter so that the host sees a clean flip-flop output rather than a compare.
  always_comb begin
    busy_next  = busy_reg;
    prog_next  = 1'b0;
    erase_next = 1'b0;
    pdata_next = pdata_reg;
    if (!op_idle) begin
      busy_next = busy_reg - 4'h1;
    end else if (op_start) begin
      busy_next  = flash_busy_cycles;
      prog_next  = !bus.program_store_erase_enable; // R11
      erase_next = bus.program_store_erase_enable; // R12
      pdata_next = bus.flash_wdata;
    end
    busy_flag_next = (busy_next != 4'h0);
  end

  // Operation registers; program and erase strobes last one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg      <= 4'h0;
      busy_flag_reg <= 1'b0;
      prog_reg      <= 1'b0;
      erase_reg     <= 1'b0;
      pdata_reg     <= reg_reset_value;
    end else begin
      busy_reg      <= busy_next;
      busy_flag_reg <= busy_flag_next;
      prog_reg      <= prog_next;
      erase_reg     <= erase_next;
      pdata_reg     <= pdata_next;
    end
  end

  // ************************************************************
  // Read-timing one-shot
  // ************************************************************
  // With a single clock the one-shot cannot be shorter than a cycle, so it is modelled as
  // a strobe that drops out every other access cycle; the bypass keeps it on throughout.
  always_comb begin
    if (timing_reg[bypass_bit]) begin
      sense_next = flash_access; // R8
    end else begin
      sense_next = flash_access && !sense_reg; // R7 R13
    end
  end

  // Sense strobe register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_reg <= 1'b0;
    end else begin
      sense_reg <= sense_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Outputs come straight from the flip-flops above.
  assign bus.sfr_rdata  = rdata_reg;
  assign bus.flash_busy = busy_flag_reg;
  assign program_byte   = prog_reg;
  assign erase_page     = erase_reg;
  assign program_data   = pdata_reg;
  assign sense_enable   = sense_reg;
  assign timing_bypass  = timing_reg[bypass_bit];
  assign lock_state     = lock_reg;

endmodule : flash_lock_device

// *** inc/flash_lock_pkg.sv ***
package flash_lock_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam logic [7:0] key_lock_offset     = 8'hb6;
  localparam logic [7:0] read_timing_offset  = 8'hb6;
  localparam logic [7:0] key_first           = 8'ha5;
  localparam logic [7:0] key_second          = 8'hf1;
  localparam logic [7:0] reg_reset_value     = 8'h00;
  localparam int         bypass_bit          = 6;
  localparam logic [7:0] read_timing_mask    = 8'h40;

  // ************************************************************
  // Host-side register offsets on APB
  // ************************************************************
  localparam logic [7:0] apb_ctrl_offset     = 8'h00;
  localparam logic [7:0] apb_key_offset      = 8'h04;
  localparam logic [7:0] apb_timing_offset   = 8'h08;
  localparam logic [7:0] apb_flash_offset    = 8'h0c;
  localparam logic [7:0] apb_status_offset   = 8'h10;

  // Control register bits on the host side.
  localparam int         ctrl_write_bit      = 0;
  localparam int         ctrl_erase_bit      = 1;
  localparam int         ctrl_timing_sel_bit = 2;

  // Cycles a write or erase takes in the flash macro.
  localparam logic [3:0] flash_busy_cycles   = 4'h4;

  typedef enum logic [1:0] {
    lock_locked   = 2'b00,
    lock_first    = 2'b01,
    lock_unlocked = 2'b10,
    lock_disabled = 2'b11
  } lock_state_e;

  typedef enum logic [1:0] {
    host_idle   = 2'b00,
    host_issue  = 2'b01,
    host_wait   = 2'b10
  } host_state_e;

endpackage : flash_lock_pkg

// *** inc/flash_lock_if.sv ***
`timescale 1ns/10ps
interface flash_lock_if (
  input wire logic pclk,
  input wire logic presetn
);
  import flash_lock_pkg::*;

  // Register port of the flash controller, as seen by the processor core.
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic       sfr_sel_timing;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  // Data-space write that may target flash.
  logic       flash_wr;
  logic [7:0] flash_wdata;
  logic       program_store_write_enable;
  logic       program_store_erase_enable;
  logic       flash_busy;

  modport device (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_sel_timing, sfr_wdata,
    input  flash_wr, flash_wdata, program_store_write_enable, program_store_erase_enable,
    output sfr_rdata, flash_busy
  );

  modport host (
    output sfr_wr, sfr_rd, sfr_addr, sfr_sel_timing, sfr_wdata,
    output flash_wr, flash_wdata, program_store_write_enable, program_store_erase_enable,
    input  sfr_rdata, flash_busy
  );

endinterface : flash_lock_if

// *** hdl/flash_lock_host.sv ***
`timescale 1ns/10ps
module flash_lock_host (
  flash_lock_if.host          bus,
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr
);
  import flash_lock_pkg::*;

  // ************************************************************
  // APB slave that drives the register port of the device
  // ************************************************************
  logic [2:0]  ctrl_reg, ctrl_next;
  logic        wr_reg, wr_next;
  logic        rd_reg, rd_next;
  logic        sel_reg, sel_next;
  logic        fwr_reg, fwr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        perr_reg, perr_next;
  host_state_e st_reg, st_next;
  logic        setup;

  assign setup = psel && !penable;

  // A key or timing read goes to the device first, so its answer takes three cycles.
  always_comb begin
    ctrl_next   = ctrl_reg;
    wr_next     = 1'b0;
    rd_next     = 1'b0;
    sel_next    = sel_reg;
    fwr_next    = 1'b0;
    wdata_next  = wdata_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    perr_next   = 1'b0;
    st_next     = st_reg;
    case (st_reg)
      host_idle: begin
        if (setup) begin
          st_next = host_issue;
        end
      end
      host_issue: begin
        st_next    = host_wait;
        wdata_next = pwdata[7:0];
        if (paddr == apb_ctrl_offset) begin
          if (pwrite) begin
            ctrl_next = pwdata[2:0];
          end
          prdata_next = {29'h0, ctrl_reg};
        end else if (paddr == apb_key_offset || paddr == apb_timing_offset) begin
          sel_next = (paddr == apb_timing_offset);
          wr_next  = pwrite;
          rd_next  = !pwrite;
        end else if (paddr == apb_flash_offset) begin
          fwr_next    = pwrite;
          prdata_next = 32'h0;
        end else if (paddr == apb_status_offset) begin
          prdata_next = {31'h0, bus.flash_busy};
        end else begin
          perr_next   = 1'b1;
          prdata_next = 32'h0;
        end
      end
      host_wait: begin
        if (sel_reg || rd_reg) begin
          prdata_next = rd_reg ? 32'h0 : prdata_reg;
        end
        if (!rd_reg) begin
          pready_next = 1'b1;
          perr_next   = perr_reg;
          st_next     = host_idle;
          if (rd_reg == 1'b0 && (paddr == apb_key_offset || paddr == apb_timing_offset) && !pwrite) begin
            prdata_next = {24'h0, bus.sfr_rdata};
          end
        end
      end
      default: st_next = host_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= 3'h0;
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      sel_reg    <= 1'b0;
      fwr_reg    <= 1'b0;
      wdata_reg  <= reg_reset_value;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      perr_reg   <= 1'b0;
      st_reg     <= host_idle;
    end else begin
      ctrl_reg   <= ctrl_next;
      wr_reg     <= wr_next;
      rd_reg     <= rd_next;
      sel_reg    <= sel_next;
      fwr_reg    <= fwr_next;
      wdata_reg  <= wdata_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      perr_reg   <= perr_next;
      st_reg     <= st_next;
    end
  end

  // Device-facing strobes, all registered.
  assign bus.sfr_wr                     = wr_reg;
  assign bus.sfr_rd                     = rd_reg;
  assign bus.sfr_addr                   = key_lock_offset;
  assign bus.sfr_sel_timing             = sel_reg;
  assign bus.sfr_wdata                  = wdata_reg;
  assign bus.flash_wr                   = fwr_reg;
  assign bus.flash_wdata                = wdata_reg;
  assign bus.program_store_write_enable = ctrl_reg[ctrl_write_bit];
  assign bus.program_store_erase_enable = ctrl_reg[ctrl_erase_bit];
  assign prdata                         = prdata_reg;
  assign pready                         = pready_reg;
  assign pslverr                        = perr_reg;

endmodule : flash_lock_host

// *** tb/flash_lock_assertions.sv ***
`timescale 1ns/10ps
module flash_lock_assertions (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_sel_timing,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       flash_wr,
  input wire logic       flash_busy
);
  import flash_lock_pkg::*;
  // ************************************************************
  // Checks on the register port between the two ends
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Busy must come from a recent flash write and last the fixed macro time.
  sequence wr_cause;
    $past(flash_wr) || $past(flash_wr, 2) || $past(flash_wr, 3);
  endsequence
  sequence busy_run;
    flash_busy [*4] ##1 !flash_busy;
  endsequence
  chk_busy_cause: assert property ($rose(flash_busy) |-> wr_cause) else $error("busy without write");
  chk_busy_length: assert property ($rose(flash_busy) |-> busy_run) else $error("busy length wrong");
  chk_wr_pulse: assert property (sfr_wr |=> !sfr_wr) else $error("register write held");
  chk_rd_pulse: assert property (sfr_rd |=> !sfr_rd) else $error("register read held");
  chk_flash_pulse: assert property (flash_wr |=> !flash_wr) else $error("flash write held");
  chk_rdata_hold: assert property ((!sfr_rd || sfr_addr != key_lock_offset) |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  chk_reserved_zero: assert property ((sfr_wr && sfr_sel_timing) |-> (sfr_wdata & ~read_timing_mask) == 8'h00)
    else $error("reserved timing bits written");
  chk_key_code: assert property ((sfr_rd && !sfr_sel_timing) |=> sfr_rdata[7:2] == 6'h00)
    else $error("lock code upper bits set");
  chk_timing_read: assert property ((sfr_rd && sfr_sel_timing) |=> (sfr_rdata & ~read_timing_mask) == 8'h00)
    else $error("timing read reserved bits set");
endmodule : flash_lock_assertions

// *** tb/tb_flash_lock_and_read_timing.sv ***
`timescale 1ns/10ps
module tb_flash_lock_and_read_timing;
  import flash_lock_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, flash_access, pready, pslverr, re;
  logic        program_byte, erase_page, sense_enable, timing_bypass;
  logic [7:0]  paddr, program_data, last_data;
  logic [31:0] pwdata, prdata, rv;
  lock_state_e lock_state;
  int          err_count, n_tests, n_prog, n_erase, cnt;
  flash_lock_if fl_if (.pclk(pclk), .presetn(presetn));
  flash_lock_device flash_lock_device_i (.bus(fl_if.device), .pclk, .presetn, .flash_access, .program_byte,
    .erase_page, .program_data, .sense_enable, .timing_bypass, .lock_state);
  flash_lock_host flash_lock_host_i (.bus(fl_if.host), .pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  flash_lock_assertions flash_lock_assertions_i (.pclk, .presetn, .sfr_wr(fl_if.sfr_wr), .sfr_rd(fl_if.sfr_rd),
    .sfr_addr(fl_if.sfr_addr), .sfr_sel_timing(fl_if.sfr_sel_timing), .sfr_wdata(fl_if.sfr_wdata),
    .sfr_rdata(fl_if.sfr_rdata), .flash_wr(fl_if.flash_wr), .flash_busy(fl_if.flash_busy));
  // ************************************************************
  // Clock, monitors and shared tasks
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Pulses are counted here so that a double pulse is seen as well as a missing one.
  always @(posedge pclk) begin
    if (program_byte === 1'b1) begin
      n_prog++;
      last_data = program_data;
    end
    if (erase_page === 1'b1) n_erase++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // One transfer; the idle edge at the end keeps two transfers from assigning psel in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    rv = prdata;
    re = pslverr;
    chk({31'h0, (n <= 3)}, 32'h1, "answer time");
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rv, exp, what);
  endtask : rd
  task automatic unlock;
    apb(1'b1, apb_key_offset, {24'h0, key_first});
    apb(1'b1, apb_key_offset, {24'h0, key_second});
  endtask : unlock
  // Polls the status word; the macro time is a design choice, so no fixed wait is assumed.
  task automatic wait_idle;
    rv = 32'h1;
    while (rv[0] !== 1'b0) begin
      apb(1'b0, apb_status_offset, 32'h0);
    end
  endtask : wait_idle
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset
  task automatic count_sense;
    cnt = 0;
    repeat (4) begin
      @(posedge pclk);
      cnt += (sense_enable === 1'b1);
    end
  endtask : count_sense
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    flash_access = 1'b0;
    do_reset;
    rd(apb_key_offset, 32'h0, "key reset");
    rd(apb_timing_offset, 32'h0, "timing reset");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, re}, 32'h1, "unmapped refused");
    $display("test reset values done");
    apb(1'b1, apb_key_offset, {24'h0, key_first});
    rd(apb_key_offset, 32'h1, "first key");
    apb(1'b1, apb_key_offset, {24'h0, key_second});
    rd(apb_key_offset, 32'h2, "unlocked");
    chk({30'h0, lock_state}, {30'h0, lock_unlocked}, "lock port");
    apb(1'b1, apb_ctrl_offset, 32'h1);
    rd(apb_ctrl_offset, 32'h1, "ctrl readback");
    apb(1'b1, apb_flash_offset, 32'h3c);
    wait_idle;
    chk(32'(n_prog), 32'h1, "program pulses");
    chk({24'h0, last_data}, 32'h3c, "program data");
    rd(apb_key_offset, 32'h0, "relocked");
    apb(1'b1, apb_flash_offset, 32'h55);
    rd(apb_key_offset, 32'h3, "write while locked");
    chk(32'(n_prog), 32'h1, "suppressed write");
    $display("test program done");
    do_reset;
    rd(apb_key_offset, 32'h0, "reset clears lock");
    unlock;
    apb(1'b1, apb_ctrl_offset, 32'h3);
    apb(1'b1, apb_flash_offset, 32'h0);
    wait_idle;
    chk(32'(n_erase), 32'h1, "erase pulses");
    chk(32'(n_prog), 32'h1, "no program on erase");
    rd(apb_key_offset, 32'h0, "relocked after erase");
    $display("test erase done");
    apb(1'b1, apb_key_offset, {24'h0, key_first});
    apb(1'b1, apb_key_offset, 32'h12);
    rd(apb_key_offset, 32'h3, "wrong second key");
    unlock;
    rd(apb_key_offset, 32'h3, "lock persists");
    apb(1'b1, apb_ctrl_offset, 32'h1);
    apb(1'b1, apb_flash_offset, 32'h11);
    chk(32'(n_prog), 32'h1, "write blocked");
    do_reset;
    apb(1'b1, apb_flash_offset, 32'h22);
    rd(apb_key_offset, 32'h0, "enable clear ignored");
    apb(1'b1, apb_key_offset, 32'h0);
    rd(apb_key_offset, 32'h3, "forced lock");
    $display("test wrong keys done");
    do_reset;
    flash_access <= 1'b1;
    apb(1'b1, apb_timing_offset, {24'h0, read_timing_mask});
    rd(apb_timing_offset, {24'h0, read_timing_mask}, "bypass set");
    chk({31'h0, timing_bypass}, 32'h1, "bypass port");
    count_sense;
    chk(32'(cnt), 32'h4, "clocked sense");
    apb(1'b1, apb_timing_offset, 32'h0);
    rd(apb_timing_offset, 32'h0, "bypass cleared");
    count_sense;
    chk(32'(cnt), 32'h2, "one-shot sense");
    flash_access <= 1'b0;
    @(posedge pclk);
    count_sense;
    chk(32'(cnt), 32'h0, "sense idle");
    $display("test read timing done");
    finish_test;
  end
  // A hung handshake ends the run through the same closing task.
  initial begin
    #100us;
    err_count++;
    $display("wrong value at %0t: run did not finish", $time);
    finish_test;
  end
endmodule : tb_flash_lock_and_read_timing
